// ### bench/pdm_power_ctrl_bench.sv
/* Bench of the power-down mode control block: registers over AXI4-Lite,
   sleep and wake sequences, settle waits. Assumes shortened wait counts. */
`default_nettype none
module pdm_power_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned W[5] = '{4, 5, 6, 7, 9};  // Short waits keep the run brief
   logic        clk = 1'b0;       // Reference clock
   logic        rst = 1'b1;       // Active-high reset
   logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [1:0]  bresp, rresp;
   logic        sleep_exec, wake_irq, timer_a, cpu_run, subclk, settling, irq_acc, lcd_en, lcd_low;
   logic [7:0]  mode;             // One-hot mode
   logic        med, osc, nf, dx; // Speed, oscillator and control two outputs
   logic [1:0]  sa;               // Subactive clock rate output
   int          num_errors = 0;
   int          tests_run = 0;
   // Clock at 125 MHz
   always #4 clk = ~clk;
   pdm_power_ctrl #(.P_WAIT_0(W[0]), .P_WAIT_1(W[1]), .P_WAIT_2(W[2]), .P_WAIT_3(W[3]), .P_WAIT_4(W[4])) uut (
      .i_ref_clk(clk), .i_sys_rst(rst), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(4'hF), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
      .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
      .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .i_sleep_exec(sleep_exec),
      .i_wake_irq(wake_irq), .i_timer_a_watch(timer_a), .o_mode(mode), .o_cpu_run(cpu_run),
      .o_cpu_subclock(subclk), .o_medium_speed(med), .o_sys_osc_run(osc), .o_settling(settling),
      .o_ext_irq_accept(irq_acc), .o_lcd_clk_en(lcd_en), .o_lcd_out_low(lcd_low), .o_noise_fast(nf),
      .o_direct_xfer(dx), .o_sub_clk_div(sa));
   // Compare and count; four-state equality so an unknown never matches
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Write one byte; handshakes are sampled mid-cycle and acted on at the edge
   task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [1:0] er);
      logic ad, wd, ta, tw, b;
      logic [1:0] r;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge clk);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= {24'h000000, d}; bready <= 1'b1;
      while (!(ad && wd)) begin
         @(negedge clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         @(posedge clk);
         if (ta) begin ad = 1'b1; awvalid <= 1'b0; end
         if (tw) begin wd = 1'b1; wvalid <= 1'b0; end
      end
      do begin @(negedge clk); b = bvalid; r = bresp; @(posedge clk); end while (b !== 1'b1);
      bready <= 1'b0;
      chk(r, er);
   endtask : wr
   // Read one word and compare data and response
   task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic t;
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      do begin @(negedge clk); t = arready; @(posedge clk); end while (t !== 1'b1);
      arvalid <= 1'b0;
      do begin @(negedge clk); t = rvalid; d = rdata; r = rresp; @(posedge clk); end while (t !== 1'b1);
      rready <= 1'b0;
      chk(d, exp);
      chk(r, er);
   endtask : rd
   // One-cycle sleep (s=1) or wake (s=0) pulse, then the new mode
   task automatic pulse(input bit s, input logic [7:0] exp);
      @(posedge clk);
      if (s) sleep_exec <= 1'b1; else wake_irq <= 1'b1;
      @(posedge clk);
      sleep_exec <= 1'b0; wake_irq <= 1'b0;
      @(negedge clk);
      chk(mode, exp);
   endtask : pulse
   // Count settle cycles, bounded, then check the mode that follows
   task automatic settle(input int unsigned n, input logic [7:0] exp);
      int unsigned c;
      c = 0;
      while (settling === 1'b1 && c < 300) begin c++; @(negedge clk); end
      chk(c, n);
      chk(mode, exp);
   endtask : settle
   task automatic results;
      $display("errors %0d comparisons %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : results
   // Watchdog well beyond the few hundred cycles the sequence needs
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      results();
   end
   // Main sequence
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, sleep_exec, wake_irq, timer_a} = 8'h00;
      {awaddr, wdata, araddr} = {32'h0, 32'h0, 32'h0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rd(pdm_pkg::PDM_CTRL1_ADDR, 32'h07, pdm_pkg::PDM_RESP_OK);
      rd(pdm_pkg::PDM_CTRL2_ADDR, 32'hE0, pdm_pkg::PDM_RESP_OK);
      rd(32'h10, 32'h0, pdm_pkg::PDM_RESP_ERR);
      wr(32'h0, 8'hFF, pdm_pkg::PDM_RESP_ERR);
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h70, pdm_pkg::PDM_RESP_OK);
      rd(pdm_pkg::PDM_CTRL1_ADDR, 32'h77, pdm_pkg::PDM_RESP_OK);
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h00, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h08);
      pulse(0, 8'h01);
      wr(pdm_pkg::PDM_CTRL2_ADDR, 8'h04, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h08);
      pulse(0, 8'h02);
      chk(med, 1'b1);
      // Every control two bit set but medium speed, outside subactive
      wr(pdm_pkg::PDM_CTRL2_ADDR, 8'h1B, pdm_pkg::PDM_RESP_OK);
      rd(pdm_pkg::PDM_CTRL2_ADDR, 32'hFB, pdm_pkg::PDM_RESP_OK);
      chk({nf, dx, sa}, 4'hF);
      // Every settle code in turn; a real system picks one per clock rate
      for (int k = 0; k < 8; k++) begin
         wr(pdm_pkg::PDM_CTRL1_ADDR, {1'b1, k[2:0], 4'h0}, pdm_pkg::PDM_RESP_OK);
         pulse(1, 8'h20);
         chk(irq_acc, 1'b0);
         chk(osc, 1'b0);
         pulse(0, 8'h80);
         settle(W[k > 3 ? 4 : k], 8'h01);
      end
      @(posedge clk);
      timer_a <= 1'b1;
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h80, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h40);
      pulse(0, 8'h80);
      settle(W[0], 8'h01);
      @(posedge clk);
      timer_a <= 1'b0;
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h88, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h40);
      pulse(0, 8'h04);
      chk(subclk, 1'b1);
      // Subactive clock rate bits must refuse this write
      wr(pdm_pkg::PDM_CTRL2_ADDR, 8'h18, pdm_pkg::PDM_RESP_OK);
      rd(pdm_pkg::PDM_CTRL2_ADDR, 32'hFB, pdm_pkg::PDM_RESP_OK);
      rd(pdm_pkg::PDM_AUX_ADDR, 32'h400, pdm_pkg::PDM_RESP_OK);
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h08, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h10);
      pulse(0, 8'h04);
      wr(pdm_pkg::PDM_CTRL1_ADDR, 8'h80, pdm_pkg::PDM_RESP_OK);
      pulse(1, 8'h40);
      pulse(0, 8'h80);
      settle(W[0], 8'h01);
      chk(cpu_run, 1'b1);
      wr(pdm_pkg::PDM_AUX_ADDR, 8'h01, pdm_pkg::PDM_RESP_OK);
      chk({lcd_en, lcd_low}, 2'h1);
      results();
   end
endmodule : pdm_power_ctrl_bench
`default_nettype wire

// ### src/pdm_pkg.sv
/*
 * Package of the power-down mode control block: register indices and byte
 * addresses, field positions, reset values, settle-wait counts, mode codes.
 * Assumes one clock of 125 MHz; one wait state equals one clock cycle.
 */
`default_nettype none
package pdm_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [15:0] PDM_CTRL1_IDX  = 16'hFFF0;
   localparam logic [15:0] PDM_CTRL2_IDX  = 16'hFFF1;
   localparam logic [15:0] PDM_AUX_IDX    = 16'hFFF2;
   localparam logic [31:0] PDM_CTRL1_ADDR = {14'h0000, PDM_CTRL1_IDX, 2'h0};
   localparam logic [31:0] PDM_CTRL2_ADDR = {14'h0000, PDM_CTRL2_IDX, 2'h0};
   localparam logic [31:0] PDM_AUX_ADDR   = {14'h0000, PDM_AUX_IDX, 2'h0};
   // Reset values
   localparam logic [7:0]  PDM_CTRL1_RST  = 8'h07;
   localparam logic [7:0]  PDM_CTRL2_RST  = 8'hE0;
   localparam logic [2:0]  PDM_CTRL1_ONES = 3'h7;   // Bits 2..0 of control one
   localparam logic [2:0]  PDM_CTRL2_ONES = 3'h7;   // Bits 7..5 of control two
   // Field positions, control one
   localparam int PDM_STANDBY_SEL_BIT = 7;
   localparam int PDM_STS_LSB         = 4;
   localparam int PDM_LOW_WAKE_BIT    = 3;
   // Field positions, control two
   localparam int PDM_NESEL_BIT    = 4;
   localparam int PDM_DTON_BIT     = 3;
   localparam int PDM_MED_WAKE_BIT = 2;
   localparam int PDM_SA_LSB       = 0;
   // Field positions, auxiliary register
   localparam int PDM_LCDSB_BIT = 0;
   localparam int PDM_MODE_LSB  = 8;
   localparam int PDM_SETL_BIT  = 16;
   // Settle waits in states (one state is one clock)
   localparam int unsigned PDM_WAIT_0 = 8192;
   localparam int unsigned PDM_WAIT_1 = 16384;
   localparam int unsigned PDM_WAIT_2 = 32768;
   localparam int unsigned PDM_WAIT_3 = 65536;
   localparam int unsigned PDM_WAIT_4 = 131072;
   // AXI responses
   localparam logic [1:0]  PDM_RESP_OK  = 2'h0;
   localparam logic [1:0]  PDM_RESP_ERR = 2'h2;
   // Operating modes, one-hot
   typedef enum logic [7:0] {
      PDM_ACT_HS   = 8'h01,
      PDM_ACT_MS   = 8'h02,
      PDM_SUBACT   = 8'h04,
      PDM_SLEEP    = 8'h08,
      PDM_SUBSLEEP = 8'h10,
      PDM_STANDBY  = 8'h20,
      PDM_WATCH    = 8'h40,
      PDM_SETTLE   = 8'h80
   } pdm_mode_e;
endpackage : pdm_pkg
`default_nettype wire

// ### src/pdm_power_ctrl.sv
/*
 * Power-down mode control: control registers on AXI4-Lite, the mode state
 * machine that reacts to the CPU sleep instruction and wake interrupts,
 * the settle wait after standby or watch, and LCD module standby.
 * Assumes sleep, wake and timer-A inputs come from logic on i_ref_clk.
 */
// The implementer's own choice: the AXI4-Lite interface to the registers.
// Function
// - Sleep from active, standby clear: sleep mode
// - Sleep from subactive, standby clear: subsleep
// - Standby set: standby or watch mode
// - Settle code picks wait of 8192..131072 states
// - Wait selected states before active after wake
// - Low-speed bit picks clock after watch
// - Control one low bits read one
// - Control one at index FFF0, reset 07
// - Control two at index FFF1, reset E0
// - LCD standby stops its clock, grounds outputs
// - External interrupts ignored in standby and watch
// - Medium-speed bit picks active speed after wake
// - Standby needs low-speed and timer bit clear
`default_nettype none
module pdm_power_ctrl #(
   parameter int unsigned P_WAIT_0 = pdm_pkg::PDM_WAIT_0,  // Settle waits in states
   parameter int unsigned P_WAIT_1 = pdm_pkg::PDM_WAIT_1,
   parameter int unsigned P_WAIT_2 = pdm_pkg::PDM_WAIT_2,
   parameter int unsigned P_WAIT_3 = pdm_pkg::PDM_WAIT_3,
   parameter int unsigned P_WAIT_4 = pdm_pkg::PDM_WAIT_4
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_sys_rst,
   input  wire logic        i_s_axi_awvalid,
   output logic             o_s_axi_awready,
   input  wire logic [31:0] i_s_axi_awaddr,
   input  wire logic        i_s_axi_wvalid,
   output logic             o_s_axi_wready,
   input  wire logic [31:0] i_s_axi_wdata,
   input  wire logic [3:0]  i_s_axi_wstrb,
   output logic             o_s_axi_bvalid,
   input  wire logic        i_s_axi_bready,
   output logic [1:0]       o_s_axi_bresp,
   input  wire logic        i_s_axi_arvalid,
   output logic             o_s_axi_arready,
   input  wire logic [31:0] i_s_axi_araddr,
   output logic             o_s_axi_rvalid,
   input  wire logic        i_s_axi_rready,
   output logic [31:0]      o_s_axi_rdata,
   output logic [1:0]       o_s_axi_rresp,
   input  wire logic        i_sleep_exec,      // CPU executes a sleep instruction
   input  wire logic        i_wake_irq,        // Accepted wake interrupt
   input  wire logic        i_timer_a_watch,   // Timer-A watch bit
   output logic [7:0]       o_mode,            // Current mode, one-hot
   output logic             o_cpu_run,         // CPU clocked
   output logic             o_cpu_subclock,    // CPU on subclock
   output logic             o_medium_speed,    // Active medium speed
   output logic             o_sys_osc_run,     // System oscillator running
   output logic             o_settling,        // Settle wait running
   output logic             o_ext_irq_accept,  // External interrupts accepted
   output logic             o_lcd_clk_en,      // LCD controller clock enable
   output logic             o_lcd_out_low,     // Force LCD outputs to ground
   output logic             o_noise_fast,      // Noise filter sampling select
   output logic             o_direct_xfer,     // Direct transfer flag
   output logic [1:0]       o_sub_clk_div      // Subactive clock rate select
);
   // All block state
   typedef struct packed {
      logic                aw_got;
      logic [31:0]         aw_addr;
      logic                w_got;
      logic [7:0]          w_data;
      logic                w_strb0;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [31:0]         rdata;
      logic [1:0]          rresp;
      logic                standby_select;            // Sleep goes to standby or watch
      logic [2:0]          sts;                       // Settle wait code
      logic                low_speed_wake_select;     // Subclock after watch
      logic                nesel;
      logic                dton;
      logic                medium_speed_wake_select;  // Medium speed after wake
      logic [1:0]          sa;
      logic                lcd_stby;  // LCD module standby
      pdm_pkg::pdm_mode_e  mode;
   } pdm_state_s;
   pdm_state_s q;
   pdm_state_s next_q;
   logic       settle_start;
   logic       settle_busy;
   logic       settle_done;
   logic [7:0] ctrl1_rd;
   logic [7:0] ctrl2_rd;
   logic [31:0] aux_rd;
   // Word match on an aligned register address
   function automatic logic pdm_hit(input logic [31:0] a, input logic [31:0] base);
      pdm_hit = (a[31:2] == base[31:2]);
   endfunction : pdm_hit
   // Read views; control register reserved bits read as one, auxiliary ones as zero
   always_comb begin
      ctrl1_rd = {q.standby_select, q.sts, q.low_speed_wake_select, pdm_pkg::PDM_CTRL1_ONES};
      ctrl2_rd = {pdm_pkg::PDM_CTRL2_ONES, q.nesel, q.dton, q.medium_speed_wake_select, q.sa};
      aux_rd   = 32'h00000000;
      aux_rd[pdm_pkg::PDM_LCDSB_BIT] = q.lcd_stby;
      aux_rd[pdm_pkg::PDM_MODE_LSB +: 8] = q.mode;
      aux_rd[pdm_pkg::PDM_SETL_BIT] = settle_busy;
   end

   // Channel readiness: one write and one read outstanding at most
   assign o_s_axi_awready = !q.aw_got && !q.bvalid;
   assign o_s_axi_wready  = !q.w_got && !q.bvalid;
   assign o_s_axi_arready = !q.rvalid;
   // Next-state logic for bus slave, registers and mode machine
   always_comb begin
      next_q = q;
      settle_start = 1'b0;
      // Address and data taken in either order
      if (i_s_axi_awvalid && o_s_axi_awready) begin
         next_q.aw_got  = 1'b1;
         next_q.aw_addr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
         next_q.w_got   = 1'b1;
         next_q.w_data  = i_s_axi_wdata[7:0];
         next_q.w_strb0 = i_s_axi_wstrb[0];
      end
      // Write commits once both halves are held
      if (q.aw_got && q.w_got) begin
         next_q.aw_got = 1'b0;
         next_q.w_got  = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp  = pdm_pkg::PDM_RESP_OK;
         if (pdm_hit(q.aw_addr, pdm_pkg::PDM_CTRL1_ADDR)) begin
            // Low three bits have no storage, so writes to them vanish
            if (q.w_strb0) begin
               next_q.standby_select = q.w_data[pdm_pkg::PDM_STANDBY_SEL_BIT];
               next_q.sts = q.w_data[pdm_pkg::PDM_STS_LSB +: 3];
               next_q.low_speed_wake_select = q.w_data[pdm_pkg::PDM_LOW_WAKE_BIT];
            end
         end else if (pdm_hit(q.aw_addr, pdm_pkg::PDM_CTRL2_ADDR)) begin
            if (q.w_strb0) begin
               next_q.nesel = q.w_data[pdm_pkg::PDM_NESEL_BIT];
               next_q.dton  = q.w_data[pdm_pkg::PDM_DTON_BIT];
               next_q.medium_speed_wake_select = q.w_data[pdm_pkg::PDM_MED_WAKE_BIT];
               // Subactive clock rate is frozen while running on it
               if (q.mode != pdm_pkg::PDM_SUBACT) begin
                  next_q.sa = q.w_data[pdm_pkg::PDM_SA_LSB +: 2];
               end
            end
         end else if (pdm_hit(q.aw_addr, pdm_pkg::PDM_AUX_ADDR)) begin
            if (q.w_strb0) begin
               next_q.lcd_stby = q.w_data[pdm_pkg::PDM_LCDSB_BIT];
            end
         end else begin
            // Unmapped address
            next_q.bresp = pdm_pkg::PDM_RESP_ERR;
         end
      end
      // Write response leaves when taken
      if (q.bvalid && i_s_axi_bready) begin
         next_q.bvalid = 1'b0;
      end
      // Read: data returned the cycle after the address
      if (q.rvalid && i_s_axi_rready) begin
         next_q.rvalid = 1'b0;
      end
      if (i_s_axi_arvalid && o_s_axi_arready) begin
         next_q.rvalid = 1'b1;
         next_q.rresp  = pdm_pkg::PDM_RESP_OK;
         if (pdm_hit(i_s_axi_araddr, pdm_pkg::PDM_CTRL1_ADDR)) begin
            next_q.rdata = {24'h000000, ctrl1_rd};
         end else if (pdm_hit(i_s_axi_araddr, pdm_pkg::PDM_CTRL2_ADDR)) begin
            next_q.rdata = {24'h000000, ctrl2_rd};
         end else if (pdm_hit(i_s_axi_araddr, pdm_pkg::PDM_AUX_ADDR)) begin
            next_q.rdata = aux_rd;
         end else begin
            next_q.rdata = 32'h00000000;
            next_q.rresp = pdm_pkg::PDM_RESP_ERR;
         end
      end
      // Mode machine; control bits are read as they stand right now
      case (q.mode)
         pdm_pkg::PDM_ACT_HS, pdm_pkg::PDM_ACT_MS: begin
            if (i_sleep_exec) begin
               if (!q.standby_select) begin
                  next_q.mode = pdm_pkg::PDM_SLEEP;
               end else if (!q.low_speed_wake_select && !i_timer_a_watch) begin
                  next_q.mode = pdm_pkg::PDM_STANDBY;
               end else begin
                  next_q.mode = pdm_pkg::PDM_WATCH;
               end
            end
         end
         pdm_pkg::PDM_SUBACT: begin
            if (i_sleep_exec) begin
               // Subactive never goes to standby
               next_q.mode = q.standby_select ? pdm_pkg::PDM_WATCH : pdm_pkg::PDM_SUBSLEEP;
            end
         end
         pdm_pkg::PDM_SLEEP: begin
            // Clock kept running, so no settle wait
            if (i_wake_irq) begin
               next_q.mode = q.medium_speed_wake_select ? pdm_pkg::PDM_ACT_MS : pdm_pkg::PDM_ACT_HS;
            end
         end
         pdm_pkg::PDM_SUBSLEEP: begin
            if (i_wake_irq) begin
               next_q.mode = pdm_pkg::PDM_SUBACT;
            end
         end
         pdm_pkg::PDM_STANDBY: begin
            if (i_wake_irq) begin
               next_q.mode  = pdm_pkg::PDM_SETTLE;
               settle_start = 1'b1;
            end
         end
         pdm_pkg::PDM_WATCH: begin
            if (i_wake_irq) begin
               if (q.low_speed_wake_select) begin
                  // Subclock never stopped, so no wait
                  next_q.mode = pdm_pkg::PDM_SUBACT;
               end else begin
                  next_q.mode  = pdm_pkg::PDM_SETTLE;
                  settle_start = 1'b1;
               end
            end
         end
         pdm_pkg::PDM_SETTLE: begin
            if (settle_done) begin
               next_q.mode = q.medium_speed_wake_select ? pdm_pkg::PDM_ACT_MS : pdm_pkg::PDM_ACT_HS;
            end
         end
         default: begin
            next_q.mode = pdm_pkg::PDM_ACT_HS;
         end
      endcase
   end

   // State register; control fields start at their documented values
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q          <= '0;
         q.standby_select <= pdm_pkg::PDM_CTRL1_RST[pdm_pkg::PDM_STANDBY_SEL_BIT];
         q.sts      <= pdm_pkg::PDM_CTRL1_RST[pdm_pkg::PDM_STS_LSB +: 3];
         q.low_speed_wake_select <= pdm_pkg::PDM_CTRL1_RST[pdm_pkg::PDM_LOW_WAKE_BIT];
         q.nesel    <= pdm_pkg::PDM_CTRL2_RST[pdm_pkg::PDM_NESEL_BIT];
         q.dton     <= pdm_pkg::PDM_CTRL2_RST[pdm_pkg::PDM_DTON_BIT];
         q.medium_speed_wake_select <= pdm_pkg::PDM_CTRL2_RST[pdm_pkg::PDM_MED_WAKE_BIT];
         q.sa       <= pdm_pkg::PDM_CTRL2_RST[pdm_pkg::PDM_SA_LSB +: 2];
         q.mode     <= pdm_pkg::PDM_ACT_HS;
      end else begin
         q <= next_q;
      end
   end

   // Settle wait counter
   pdm_settle_timer #(
      .P_WAIT_0 (P_WAIT_0),
      .P_WAIT_1 (P_WAIT_1),
      .P_WAIT_2 (P_WAIT_2),
      .P_WAIT_3 (P_WAIT_3),
      .P_WAIT_4 (P_WAIT_4)
   ) u_settle (
      .i_ref_clk (i_ref_clk),
      .i_sys_rst (i_sys_rst),
      .i_start   (settle_start),
      .i_sel     (q.sts),
      .o_busy    (settle_busy),
      .o_done    (settle_done)
   );

   // Outputs from the registered state: bus, control fields, mode decodes, timer busy
   assign o_s_axi_bvalid   = q.bvalid;
   assign o_s_axi_bresp    = q.bresp;
   assign o_s_axi_rvalid   = q.rvalid;
   assign o_s_axi_rdata    = q.rdata;
   assign o_s_axi_rresp    = q.rresp;
   assign o_mode           = q.mode;
   assign o_cpu_run        = (q.mode == pdm_pkg::PDM_ACT_HS) || (q.mode == pdm_pkg::PDM_ACT_MS)
                             || (q.mode == pdm_pkg::PDM_SUBACT);
   assign o_cpu_subclock   = (q.mode == pdm_pkg::PDM_SUBACT) || (q.mode == pdm_pkg::PDM_SUBSLEEP);
   assign o_medium_speed   = (q.mode == pdm_pkg::PDM_ACT_MS);
   assign o_sys_osc_run    = (q.mode != pdm_pkg::PDM_STANDBY) && (q.mode != pdm_pkg::PDM_WATCH);
   assign o_settling       = settle_busy;
   assign o_ext_irq_accept = (q.mode != pdm_pkg::PDM_STANDBY) && (q.mode != pdm_pkg::PDM_WATCH);
   assign o_lcd_clk_en     = !q.lcd_stby;
   assign o_lcd_out_low    = q.lcd_stby;
   assign o_noise_fast     = q.nesel;
   assign o_direct_xfer    = q.dton;
   assign o_sub_clk_div    = q.sa;

   // Sleep with standby clear goes to sleep mode
   sleep_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_cpu_run && !o_cpu_subclock && i_sleep_exec && !q.standby_select |=> (q.mode == pdm_pkg::PDM_SLEEP))
      else $error("Sleep instruction did not enter sleep mode");
   subsleep_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_SUBACT) && i_sleep_exec && !q.standby_select |=> (q.mode == pdm_pkg::PDM_SUBSLEEP))
      else $error("Subactive sleep did not enter subsleep");
   watch_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_SUBACT) && i_sleep_exec && q.standby_select |=> (q.mode == pdm_pkg::PDM_WATCH))
      else $error("Subactive sleep with standby set missed watch");
   standby_entry_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_cpu_run && !o_cpu_subclock && i_sleep_exec && q.standby_select
      |=> (q.mode == ((!$past(q.low_speed_wake_select) && !$past(i_timer_a_watch))
                      ? pdm_pkg::PDM_STANDBY : pdm_pkg::PDM_WATCH)))
      else $error("Standby or watch choice wrong");
   ctrl1_ones_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_s_axi_arvalid && o_s_axi_arready && pdm_hit(i_s_axi_araddr, pdm_pkg::PDM_CTRL1_ADDR)
      |=> o_s_axi_rvalid && (o_s_axi_rdata[2:0] == 3'h7))
      else $error("Control one low bits not read as one");
   ctrl1_write_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      q.aw_got && q.w_got && q.w_strb0 && pdm_hit(q.aw_addr, pdm_pkg::PDM_CTRL1_ADDR)
      |=> (ctrl1_rd == {$past(q.w_data[7:3]), 3'h7}) && o_s_axi_bvalid)
      else $error("Control one write not stored");
   wake_speed_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      ((q.mode == pdm_pkg::PDM_SLEEP) && i_wake_irq) || settle_done
      |=> (o_medium_speed == $past(q.medium_speed_wake_select)) && o_cpu_run && !o_cpu_subclock)
      else $error("Wake speed does not follow medium-speed bit");
   watch_exit_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_WATCH) && i_wake_irq
      |=> ($past(q.low_speed_wake_select) ? (q.mode == pdm_pkg::PDM_SUBACT) : (o_settling && !o_cpu_run)))
      else $error("Watch exit clock choice wrong");
   irq_gate_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_STANDBY) || (q.mode == pdm_pkg::PDM_WATCH) |-> !o_ext_irq_accept)
      else $error("External interrupts accepted in standby or watch");
   lcd_stby_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_lcd_out_low |-> !o_lcd_clk_en)
      else $error("LCD standby left its clock running");

   sleep_wake_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_SLEEP) ##1 o_cpu_run);
   standby_settle_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_STANDBY) ##1 o_settling);
   watch_sub_c: cover property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (q.mode == pdm_pkg::PDM_WATCH) ##1 (q.mode == pdm_pkg::PDM_SUBACT));
endmodule : pdm_power_ctrl
`default_nettype wire

// ### src/pdm_settle_timer.sv
/*
 * Oscillator settle-wait timer: counts the selected number of states.
 * Assumes i_start is a one-cycle pulse from logic on the same clock.
 */
`default_nettype none
module pdm_settle_timer #(
   parameter int unsigned P_WAIT_0 = pdm_pkg::PDM_WAIT_0,
   parameter int unsigned P_WAIT_1 = pdm_pkg::PDM_WAIT_1,
   parameter int unsigned P_WAIT_2 = pdm_pkg::PDM_WAIT_2,
   parameter int unsigned P_WAIT_3 = pdm_pkg::PDM_WAIT_3,
   parameter int unsigned P_WAIT_4 = pdm_pkg::PDM_WAIT_4
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_sys_rst,
   input  wire logic       i_start,   // Begin a wait
   input  wire logic [2:0] i_sel,     // Wait code
   output logic            o_busy,    // Wait running
   output logic            o_done     // Last wait cycle
);
   // Timer state
   typedef struct packed {
      logic [17:0] cnt;
      logic        busy;
   } pdm_tmr_s;

   pdm_tmr_s q;
   pdm_tmr_s next_q;

   // Top code bit set gives the longest wait regardless of low bits
   always_comb begin
      next_q = q;
      if (i_start) begin
         next_q.busy = 1'b1;
         if (i_sel[2]) begin
            next_q.cnt = 18'(P_WAIT_4);
         end else begin
            case (i_sel[1:0])
               2'h0:    next_q.cnt = 18'(P_WAIT_0);
               2'h1:    next_q.cnt = 18'(P_WAIT_1);
               2'h2:    next_q.cnt = 18'(P_WAIT_2);
               default: next_q.cnt = 18'(P_WAIT_3);
            endcase
         end
      end else if (q.busy) begin
         // Busy for exactly the loaded number of cycles
         next_q.cnt = q.cnt - 18'h00001;
         if (q.cnt == 18'h00001) begin
            next_q.busy = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_busy = q.busy;
   assign o_done = q.busy && (q.cnt == 18'h00001);

   // Shortest wait is loaded for code zero
   wait_code0_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_start && (i_sel == 3'h0) |=> o_busy && (q.cnt == 18'(P_WAIT_0)))
      else $error("Wait code zero did not load the shortest wait");
   // Any code with top bit set loads the longest wait
   wait_code4_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_start && i_sel[2] |=> (q.cnt == 18'(P_WAIT_4)))
      else $error("Top wait code bit did not load the longest wait");
   // Busy only drops on the done cycle
   busy_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_busy && !o_done && !i_start |=> o_busy)
      else $error("Settle wait ended early");
endmodule : pdm_settle_timer
`default_nettype wire
